// [src/gpp_consts.vh]
/*
  Constants for the general-purpose pin port: register offsets, field
  positions, reset values and pin groupings.
  Assumes it is included by its bare name from the port's design files.
*/
`ifndef GPP_CONSTS_VH
`define GPP_CONSTS_VH

`define GPP_NPINS 20
`define GPP_AW 8
`define GPP_DW 32

`define GPP_OFF_DIR 8'h00
`define GPP_OFF_DOUT 8'h04
`define GPP_OFF_DIN 8'h08
`define GPP_OFF_ODRAIN 8'h0c
`define GPP_OFF_OSRC 8'h10
`define GPP_OFF_FILT 8'h14
`define GPP_OFF_RISE 8'h18
`define GPP_OFF_FALL 8'h1c
`define GPP_OFF_IFLAG 8'h20
`define GPP_OFF_IFCLR 8'h24
`define GPP_OFF_IEN 8'h28
`define GPP_OFF_WAKE 8'h2c
`define GPP_OFF_WPOL 8'h30
`define GPP_OFF_SWAKE 8'h34
`define GPP_OFF_ROUTE0 8'h38
`define GPP_OFF_ROUTE1 8'h3c

`define GPP_RT_PIN_MSB 4
`define GPP_RT_PIN_LSB 0
`define GPP_RT_EN_BIT 8
`define GPP_RT_MASK 32'h0000011f

`define GPP_RST_PINS 20'h00000
`define GPP_RST_ROUTE 32'h00000000
`define GPP_RST_OE_N 20'hfffff

`define GPP_PORT_AB_MASK 20'h007ff
`define GPP_PORT_CD_MASK 20'hff800
`define GPP_SHUTOFF_CAP_MASK 20'h00249

`define GPP_FILT_TAPS 2

`endif

// [src/gpp_infilt.v]
/*
  Input conditioning for all pins: a two-stage synchronizer per pin,
  followed by an optional glitch filter that only passes a level that
  has been seen on three successive clock edges.
  Assumes pad inputs may be asynchronous to i_clk.
*/
`timescale 1ns/1ps
`include "gpp_consts.vh"

module gpp_infilt (
  input wire i_clk,
  input wire i_rst_n,
  input wire [`GPP_NPINS-1:0] i_pad,
  input wire [`GPP_NPINS-1:0] i_filt_en,
  output wire [`GPP_NPINS-1:0] o_level
);

  reg [`GPP_NPINS-1:0] meta_ff;
  reg [`GPP_NPINS-1:0] sync_ff;
  reg [`GPP_NPINS-1:0] hist1_ff;
  reg [`GPP_NPINS-1:0] hist2_ff;
  reg [`GPP_NPINS-1:0] level_ff;

  genvar g;
  generate
    for (g = 0; g < `GPP_NPINS; g = g + 1) begin : g_pin
      // The first stage feeds the second stage only.
      always @(posedge i_clk) begin
        if (!i_rst_n) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= i_pad[g];
          sync_ff[g] <= meta_ff[g];
        end
      end

      always @(posedge i_clk) begin
        if (!i_rst_n) begin
          hist1_ff[g] <= 1'b0;
          hist2_ff[g] <= 1'b0;
          level_ff[g] <= 1'b0;
        end else begin
          hist1_ff[g] <= sync_ff[g];
          hist2_ff[g] <= hist1_ff[g];
          if (!i_filt_en[g]) begin
            level_ff[g] <= sync_ff[g];
          end else if ((sync_ff[g] == hist1_ff[g]) && (hist1_ff[g] == hist2_ff[g])) begin
            level_ff[g] <= sync_ff[g];
          end
        end
      end
    end
  endgenerate

  assign o_level = level_ff;

endmodule // gpp_infilt

// [src/gpp_port.v]
/*
  General-purpose pin port top: register file, per-pin drive modes,
  peripheral routing and override, input conditioning, edge interrupts,
  event outputs, and low-energy hold and wake behaviour.
  Assumes a plain register port with read data one cycle after the
  read strobe, and a power controller that drives the sleep inputs.
*/
// What this block does
// - Twenty pins, each separately set as input or output.
// - Per-pin open-drain, open-source and input glitch filter options.
// - A routed peripheral connection overrides the pin's software function.
// - Each peripheral connection can be placed on any selectable pin.
// - Sampled pin levels are offered to the event routing network.
// - Wake-enabled pin levels raise o_async_irq without a clock; edge interrupt flags are clocked.
// - First two ports keep working during deep sleep.
// - First two ports' pins can wake the device from deep sleep.
// - Third and fourth ports hold their state throughout deep sleep.
// - A small pin subset can wake the device from shutoff mode.
`timescale 1ns/1ps
`include "gpp_consts.vh"

module gpp_port (
  input wire i_clk,
  input wire i_rst_n,
  input wire [`GPP_AW-1:0] i_addr,
  input wire [`GPP_DW-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [`GPP_DW-1:0] o_rdata,
  input wire [`GPP_NPINS-1:0] i_pad_in,
  output wire [`GPP_NPINS-1:0] o_pad_out,
  output wire [`GPP_NPINS-1:0] o_pad_oe_n,
  input wire [1:0] i_per_out,
  input wire [1:0] i_per_oe,
  output wire [1:0] o_per_in,
  output wire [`GPP_NPINS-1:0] o_evt_level,
  input wire i_deep_sleep_mode,
  input wire i_shutoff_mode,
  output wire o_irq,
  output wire o_async_irq,
  output wire o_sleep_wake,
  output wire o_shutoff_wake
);

  // One-hot pin selected by a route register, zero when disabled.
  function [`GPP_NPINS-1:0] route_mask;
    input [`GPP_DW-1:0] r;
    integer k;
    begin
      route_mask = {`GPP_NPINS{1'b0}};
      for (k = 0; k < `GPP_NPINS; k = k + 1) begin
        if (r[`GPP_RT_EN_BIT] && (r[`GPP_RT_PIN_MSB:`GPP_RT_PIN_LSB] == k[4:0])) begin
          route_mask[k] = 1'b1;
        end
      end
    end
  endfunction

  reg [`GPP_NPINS-1:0] dir_ff;
  reg [`GPP_NPINS-1:0] dout_ff;
  reg [`GPP_NPINS-1:0] odrain_ff;
  reg [`GPP_NPINS-1:0] osrc_ff;
  reg [`GPP_NPINS-1:0] filt_ff;
  reg [`GPP_NPINS-1:0] rise_ff;
  reg [`GPP_NPINS-1:0] fall_ff;
  reg [`GPP_NPINS-1:0] iflag_ff;
  reg [`GPP_NPINS-1:0] ien_ff;
  reg [`GPP_NPINS-1:0] wake_ff;
  reg [`GPP_NPINS-1:0] wpol_ff;
  reg [`GPP_NPINS-1:0] swake_ff;
  reg [`GPP_DW-1:0] route0_ff;
  reg [`GPP_DW-1:0] route1_ff;
  reg [`GPP_DW-1:0] rdata_ff;
  reg [`GPP_NPINS-1:0] prev_ff;
  reg [`GPP_NPINS-1:0] pad_out_ff;
  reg [`GPP_NPINS-1:0] pad_oe_n_ff;

  reg [`GPP_DW-1:0] nxt_rdata;
  reg [`GPP_NPINS-1:0] nxt_iflag;
  reg [`GPP_NPINS-1:0] nxt_pad_out;
  reg [`GPP_NPINS-1:0] nxt_pad_oe_n;

  wire [`GPP_NPINS-1:0] din;
  wire [`GPP_NPINS-1:0] m0;
  wire [`GPP_NPINS-1:0] m1;
  wire [`GPP_NPINS-1:0] ovr;
  wire [`GPP_NPINS-1:0] per_val;
  wire [`GPP_NPINS-1:0] per_en;
  wire [`GPP_NPINS-1:0] val;
  wire [`GPP_NPINS-1:0] en;
  wire [`GPP_NPINS-1:0] drive;
  wire [`GPP_NPINS-1:0] edge_evt;
  wire [`GPP_NPINS-1:0] clr_bits;
  wire [`GPP_NPINS-1:0] pad_match;
  wire [`GPP_NPINS-1:0] hold_bits;
  wire wr_cmd;

  assign wr_cmd = i_wr;

  gpp_infilt u_infilt (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pad(i_pad_in),
    .i_filt_en(filt_ff),
    .o_level(din)
  );

  // Software-visible configuration.
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      dir_ff <= `GPP_RST_PINS;
      dout_ff <= `GPP_RST_PINS;
      odrain_ff <= `GPP_RST_PINS;
      osrc_ff <= `GPP_RST_PINS;
      filt_ff <= `GPP_RST_PINS;
      rise_ff <= `GPP_RST_PINS;
      fall_ff <= `GPP_RST_PINS;
      ien_ff <= `GPP_RST_PINS;
      wake_ff <= `GPP_RST_PINS;
      wpol_ff <= `GPP_RST_PINS;
      swake_ff <= `GPP_RST_PINS;
      route0_ff <= `GPP_RST_ROUTE;
      route1_ff <= `GPP_RST_ROUTE;
    end else if (wr_cmd) begin
      case (i_addr)
        `GPP_OFF_DIR: dir_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_DOUT: dout_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_ODRAIN: odrain_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_OSRC: osrc_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_FILT: filt_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_RISE: rise_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_FALL: fall_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_IEN: ien_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_WAKE: wake_ff <= i_wdata[`GPP_NPINS-1:0] & `GPP_PORT_AB_MASK;
        `GPP_OFF_WPOL: wpol_ff <= i_wdata[`GPP_NPINS-1:0];
        `GPP_OFF_SWAKE: swake_ff <= i_wdata[`GPP_NPINS-1:0] & `GPP_SHUTOFF_CAP_MASK;
        `GPP_OFF_ROUTE0: route0_ff <= i_wdata & `GPP_RT_MASK;
        `GPP_OFF_ROUTE1: route1_ff <= i_wdata & `GPP_RT_MASK;
        default: begin
        end
      endcase
    end
  end

  // Peripheral routing: connection 0 wins when both pick the same pin.
  assign m0 = route_mask(route0_ff);
  assign m1 = route_mask(route1_ff) & ~m0;
  assign ovr = m0 | m1;
  assign per_val = (m0 & {`GPP_NPINS{i_per_out[0]}}) | (m1 & {`GPP_NPINS{i_per_out[1]}});
  assign per_en = (m0 & {`GPP_NPINS{i_per_oe[0]}}) | (m1 & {`GPP_NPINS{i_per_oe[1]}});
  assign val = (ovr & per_val) | (~ovr & dout_ff);
  assign en = (ovr & per_en) | (~ovr & dir_ff);

  // Open-drain drives only low, open-source only high; open-drain wins.
  assign drive = en & ((odrain_ff & ~val) | (~odrain_ff & osrc_ff & val) |
                       (~odrain_ff & ~osrc_ff));

  // During deep sleep the third and fourth ports keep their entry state.
  assign hold_bits = i_deep_sleep_mode ? `GPP_PORT_CD_MASK : {`GPP_NPINS{1'b0}};

  always @* begin
    nxt_pad_out = (hold_bits & pad_out_ff) | (~hold_bits & val);
    nxt_pad_oe_n = (hold_bits & pad_oe_n_ff) | (~hold_bits & ~drive);
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pad_out_ff <= `GPP_RST_PINS;
      pad_oe_n_ff <= `GPP_RST_OE_N;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_n_ff <= nxt_pad_oe_n;
    end
  end

  assign o_pad_out = pad_out_ff;
  assign o_pad_oe_n = pad_oe_n_ff;

  // Routed pins feed their level back to the owning peripheral.
  assign o_per_in[0] = |(m0 & din);
  assign o_per_in[1] = |(m1 & din);
  assign o_evt_level = din;

  // Edge flags are sticky; a new edge beats a clear in the same cycle.
  assign edge_evt = (rise_ff & din & ~prev_ff) | (fall_ff & ~din & prev_ff);
  assign clr_bits = (wr_cmd && (i_addr == `GPP_OFF_IFCLR)) ?
                    i_wdata[`GPP_NPINS-1:0] : {`GPP_NPINS{1'b0}};

  always @* begin
    nxt_iflag = (iflag_ff & ~clr_bits) | edge_evt;
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      prev_ff <= `GPP_RST_PINS;
      iflag_ff <= `GPP_RST_PINS;
    end else begin
      prev_ff <= din;
      iflag_ff <= nxt_iflag;
    end
  end

  assign o_irq = |(iflag_ff & ien_ff);

  // Clockless pad-level detection for interrupts and wake-up.
  assign pad_match = ~(i_pad_in ^ wpol_ff);
  assign o_async_irq = |(wake_ff & pad_match);
  assign o_sleep_wake = i_deep_sleep_mode & (|(wake_ff & pad_match));
  assign o_shutoff_wake = i_shutoff_mode & (|(swake_ff & pad_match));

  // Register read port: data stands in the cycle after the strobe.
  always @* begin
    nxt_rdata = {`GPP_DW{1'b0}};
    if (i_rd) begin
      case (i_addr)
        `GPP_OFF_DIR: nxt_rdata[`GPP_NPINS-1:0] = dir_ff;
        `GPP_OFF_DOUT: nxt_rdata[`GPP_NPINS-1:0] = dout_ff;
        `GPP_OFF_DIN: nxt_rdata[`GPP_NPINS-1:0] = din;
        `GPP_OFF_ODRAIN: nxt_rdata[`GPP_NPINS-1:0] = odrain_ff;
        `GPP_OFF_OSRC: nxt_rdata[`GPP_NPINS-1:0] = osrc_ff;
        `GPP_OFF_FILT: nxt_rdata[`GPP_NPINS-1:0] = filt_ff;
        `GPP_OFF_RISE: nxt_rdata[`GPP_NPINS-1:0] = rise_ff;
        `GPP_OFF_FALL: nxt_rdata[`GPP_NPINS-1:0] = fall_ff;
        `GPP_OFF_IFLAG: nxt_rdata[`GPP_NPINS-1:0] = iflag_ff;
        `GPP_OFF_IEN: nxt_rdata[`GPP_NPINS-1:0] = ien_ff;
        `GPP_OFF_WAKE: nxt_rdata[`GPP_NPINS-1:0] = wake_ff;
        `GPP_OFF_WPOL: nxt_rdata[`GPP_NPINS-1:0] = wpol_ff;
        `GPP_OFF_SWAKE: nxt_rdata[`GPP_NPINS-1:0] = swake_ff;
        `GPP_OFF_ROUTE0: nxt_rdata = route0_ff;
        `GPP_OFF_ROUTE1: nxt_rdata = route1_ff;
        default: nxt_rdata = {`GPP_DW{1'b0}};
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= {`GPP_DW{1'b0}};
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

endmodule // gpp_port

// [test/gpp_port_chk_sva.sv]
/*
  Checker for the pin port: read data, pin hold in deep sleep, event levels
  and wake outputs.
  Assumes it is bound to gpp_port and sees only its ports.
*/
`timescale 1ns/1ps
module gpp_port_chk (
  input wire i_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire [19:0] i_pad_in,
  input wire [19:0] o_pad_out,
  input wire [19:0] o_pad_oe_n,
  input wire [1:0] o_per_in,
  input wire [19:0] o_evt_level,
  input wire i_deep_sleep_mode,
  input wire i_shutoff_mode,
  input wire o_irq,
  input wire o_async_irq,
  input wire o_sleep_wake,
  input wire o_shutoff_wake
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not idle");
  pin_hi_zero_a: assert property (i_rd && i_addr < 8'h38 |=> o_rdata[31:20] == 12'h0)
    else $error("pin register high bits set");
  no_data_rd_a: assert property (i_rd && (i_addr == 8'h24 || i_addr > 8'h3c) |=> o_rdata == 0)
    else $error("write-only or unmapped read not zero");
  evt_rise_a: assert property ((o_evt_level & ~$past(o_evt_level) & ~$past(i_pad_in, 3)) == 0)
    else $error("event level rose too early");
  evt_fall_a: assert property ((~o_evt_level & $past(o_evt_level) & $past(i_pad_in, 3)) == 0)
    else $error("event level fell too early");
  per_in_src_a: assert property (|o_per_in |-> |o_evt_level)
    else $error("peripheral input without pin level");
  hold_c_d_a: assert property (i_deep_sleep_mode && $past(i_deep_sleep_mode) |->
    $stable(o_pad_out[19:11]) && $stable(o_pad_oe_n[19:11])) else $error("held pins moved");
  sleep_wake_a: assert property (o_sleep_wake == (i_deep_sleep_mode && o_async_irq))
    else $error("sleep wake mismatch");
  shutoff_wake_a: assert property (o_shutoff_wake |-> i_shutoff_mode)
    else $error("shutoff wake outside shutoff");
  cover property (o_irq);
  cover property (o_sleep_wake);
  cover property (o_shutoff_wake);
endmodule // gpp_port_chk

bind gpp_port gpp_port_chk u_gpp_port_chk (.*);

// [test/gpp_board.sv]
/*
  Board model on the pads: a pull-up on every pad, and a weak bench source.
  Assumes active-low pad enables from the port.
*/
`timescale 1ns/1ps
module gpp_board (
  input wire [19:0] i_pad_out,
  input wire [19:0] i_pad_oe_n,
  input wire [19:0] i_ext_val,
  input wire [19:0] i_ext_en,
  output wire [19:0] o_pad
);
  // The port's driver beats the bench source, which beats the pull-up.
  assign o_pad = (~i_pad_oe_n & i_pad_out) | (i_pad_oe_n & ~i_ext_en) |
    (i_pad_oe_n & i_ext_en & i_ext_val);
endmodule // gpp_board

// [test/tb.sv]
/*
  Self-checking bench for the pin port with a board model on the pads.
  Assumes the register map of gpp_consts.vh and a 20 MHz clock.
*/
`timescale 1ns/1ps
`include "gpp_consts.vh"
module tb;
  reg i_clk, i_rst_n, i_wr, i_rd, slp, off;
  reg [7:0] i_addr;
  reg [31:0] i_wdata;
  reg [1:0] p_out, p_oe;
  reg [19:0] x_val, x_en;
  wire [19:0] pad, p_o, oe_n, evt;
  wire [31:0] rdata;
  wire [1:0] p_in;
  wire irq, airq, swk, owk;
  integer bad_count, n_checks;
  gpp_port u_gpp_port (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_pad_in(pad), .o_pad_out(p_o),
    .o_pad_oe_n(oe_n), .i_per_out(p_out), .i_per_oe(p_oe), .o_per_in(p_in),
    .o_evt_level(evt), .i_deep_sleep_mode(slp), .i_shutoff_mode(off), .o_irq(irq),
    .o_async_irq(airq), .o_sleep_wake(swk), .o_shutoff_wake(owk));
  gpp_board u_gpp_board (.i_pad_out(p_o), .i_pad_oe_n(oe_n), .i_ext_val(x_val),
    .i_ext_en(x_en), .o_pad(pad));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("FAIL %0t saw %h expected %h", $time, s, e);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge i_clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    stop_test;
  end
  initial begin
    {i_rst_n, i_wr, i_rd, slp, off, p_out, p_oe, i_addr, i_wdata, x_val} = 0;
    x_en = 20'h00038;
    bad_count = 0;
    n_checks = 0;
    cyc(10);
    i_rst_n <= 1'b1;
    cyc(1);
    chk(oe_n, 20'hfffff);
    chk(p_o, 0);
    rd(8'h40, 0);
    rd(`GPP_OFF_IFCLR, 0);
    rd(`GPP_OFF_DIN, 32'h000fffc7);
    $display("reset test done");
    wr(`GPP_OFF_DIR, 7);
    wr(`GPP_OFF_ODRAIN, 2);
    wr(`GPP_OFF_OSRC, 4);
    wr(`GPP_OFF_DOUT, 7);
    cyc(1);
    chk(oe_n, 20'hffffa);
    chk(p_o, 7);
    wr(`GPP_OFF_DOUT, 0);
    cyc(1);
    chk(oe_n, 20'hffffc);
    cyc(4);
    chk(evt, 32'h000fffc4);
    rd(`GPP_OFF_DIN, 32'h000fffc4);
    $display("drive test done");
    wr(`GPP_OFF_RISE, 32'h20);
    wr(`GPP_OFF_IEN, 32'h20);
    x_val[5] <= 1'b1;
    cyc(5);
    chk(irq, 1);
    rd(`GPP_OFF_IFLAG, 32'h20);
    wr(`GPP_OFF_IEN, 0);
    cyc(1);
    chk(irq, 0);
    wr(`GPP_OFF_IFCLR, 32'h20);
    rd(`GPP_OFF_IFLAG, 0);
    wr(`GPP_OFF_FALL, 32'h20);
    x_val[5] <= 1'b0;
    cyc(5);
    rd(`GPP_OFF_IFLAG, 32'h20);
    $display("interrupt test done");
    wr(`GPP_OFF_DIR, 32'h1007);
    wr(`GPP_OFF_DOUT, 32'h1001);
    wr(`GPP_OFF_WPOL, 32'h18);
    wr(`GPP_OFF_WAKE, 32'h10);
    wr(`GPP_OFF_SWAKE, 32'h08);
    cyc(1);
    chk(airq, 0);
    slp <= 1'b1;
    x_val[4] <= 1'b1;
    #1 chk({airq, swk}, 2'b11);
    wr(`GPP_OFF_DOUT, 0);
    cyc(1);
    chk(p_o, 20'h01000);
    slp <= 1'b0;
    off <= 1'b1;
    x_val[3] <= 1'b1;
    #1 chk({swk, owk}, 2'b01);
    cyc(2);
    chk(p_o, 0);
    off <= 1'b0;
    $display("sleep test done");
    wr(`GPP_OFF_DOUT, 32'h80);
    wr(`GPP_OFF_ROUTE0, 32'h107);
    wr(`GPP_OFF_ROUTE1, 32'h109);
    p_oe <= 2'b01;
    cyc(2);
    chk({p_o[7], oe_n[7]}, 2'b00);
    cyc(4);
    chk(p_in, 2'b10);
    p_out <= 2'b11;
    p_oe <= 2'b11;
    cyc(2);
    chk({p_o[7], p_o[9], oe_n[9]}, 3'b110);
    $display("routing test done");
    wr(`GPP_OFF_FILT, 32'h20);
    @(posedge i_clk);
    x_val[5] <= 1'b1;
    cyc(4);
    chk(evt[5], 0);
    cyc(2);
    chk(evt[5], 1);
    wr(`GPP_OFF_IFCLR, 32'h20);
    x_val[5] <= 1'b0;
    @(posedge i_clk);
    x_val[5] <= 1'b1;
    cyc(6);
    rd(`GPP_OFF_IFLAG, 0);
    $display("filter test done");
    stop_test;
  end
endmodule // tb
